// *** rtc_defs.svh ***
/*
  Constants of the clock-output, interrupt, bus-timeout and nonvolatile-write gate block.
  Assumes a 125 MHz system clock; included by bare name.
*/
// Notes on behaviour
// - With the enable pin high the clock output runs at 32768 Hz for select 00 or 11, 1024 Hz for 01, 1 Hz for 10.
// - With the enable pin low the clock output is high impedance whatever the select holds.
// - After power-on the clock output starts at 32.768 kHz when the enable pin is high.
// - Alarm, interval timer and time-update events pull the open-drain interrupt line low.
// - A transaction open for 0.95 s or more resets the serial interface; time may lag up to 1 s.
// - Nonvolatile access is refused for 30 ms after power-on; the bench host tries one byte then and gets a nack.
// - No nonvolatile write happens before the crystal oscillator has started.
// - Nonvolatile writes are taken only while the write-permit bit is 1; it clears at power-up.
// - No sequential multi-byte nonvolatile write; one transaction stores one byte.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define MCLK_HZ       125000000
`define CNT_W         27
`define F_HI_HZ       32768
`define F_MID_HZ      1024
`define F_LO_HZ       1
`define T_PUA_MS      30
`define T_WR_US       1800
`define T_BUSTO_MS    950
`define HALF_HI_CYC   (`MCLK_HZ / (2 * `F_HI_HZ))
`define HALF_MID_CYC  (`MCLK_HZ / (2 * `F_MID_HZ))
`define HALF_LO_CYC   (`MCLK_HZ / (2 * `F_LO_HZ))
`define PUA_CYC       ((`MCLK_HZ / 1000) * `T_PUA_MS)
`define WR_CYC        ((`MCLK_HZ / 1000000) * `T_WR_US)
`define BUSTO_CYC     ((`MCLK_HZ / 1000) * `T_BUSTO_MS)
`define FSEL_HI_A     2'h0
`define FSEL_MID      2'h1
`define FSEL_LO       2'h2
`define FSEL_HI_B     2'h3
`define NVM_ADDR_W    4
`endif

// *** rtc_pkg.sv ***
/*
  Types shared by the block: write request carrier, interrupt sources, gate states.
  Assumes rtc_defs.svh is on the include path.
*/
`include "rtc_defs.svh"
package rtc_pkg;
  typedef logic [1:0] fsel_t;
  typedef struct packed {
    logic [`NVM_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } nvm_req_s;
  typedef struct packed {
    logic alarm;
    logic timer;
    logic update;
  } irq_src_s;
  typedef enum logic [1:0] {ST_LOCKOUT, ST_IDLE, ST_BUSY} gate_e;
endpackage : rtc_pkg

// *** rtc_sync2.sv ***
/*
  Two-flop synchroniser, one bit lane per input bit.
  Assumes each lane is a level or a toggle that holds for several destination cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : rtc_sync2
`default_nettype wire

// *** rtc_ctl.sv ***
/*
  Clock-output driver, interrupt line driver, bus transaction watchdog and
  nonvolatile write gate. The bus front end lives in bus_clk_i domain and hands
  start, stop and byte-write requests here; the write engine and the rest of
  the device sit on mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_ctl #(
  parameter logic [`CNT_W-1:0] PUA_CYC     = `CNT_W'(`PUA_CYC),
  parameter logic [`CNT_W-1:0] WR_CYC      = `CNT_W'(`WR_CYC),
  parameter logic [`CNT_W-1:0] BUSTO_CYC   = `CNT_W'(`BUSTO_CYC),
  parameter logic [`CNT_W-1:0] HALF_LO_CYC = `CNT_W'(`HALF_LO_CYC),
  parameter logic [`CNT_W-1:0] HALF_MD_CYC = `CNT_W'(`HALF_MID_CYC)
) (
  // clocks and reset
  input  wire logic              mclk_i,
  input  wire logic              bus_clk_i,
  input  wire logic              resetn_i,
  // pins
  input  wire logic              clock_out_enable_pin_i,
  input  wire logic              osc_running_i,
  output var  logic              clock_out_pin_o,
  output var  logic              clock_out_pin_oe_n_o,
  output var  logic              irq_n_o,
  output var  logic              irq_oe_n_o,
  // device state on mclk_i
  input  wire rtc_pkg::fsel_t    fsel_i,
  input  wire logic              nvm_write_permit_i,
  input  wire rtc_pkg::irq_src_s irq_src_i,
  output var  logic              nvm_wr_o,
  output var  rtc_pkg::nvm_req_s nvm_wdata_o,
  output var  logic              bus_reset_o,
  // bus front end on bus_clk_i
  input  wire logic              bus_start_i,
  input  wire logic              bus_stop_i,
  input  wire logic              wr_req_i,
  input  wire rtc_pkg::nvm_req_s wr_data_i,
  output logic                   wr_ack_o,
  output logic                   wr_nack_o,
  output logic                   bus_abort_o
);
  // system-clock side state
  rtc_pkg::gate_e    state, next_state;
  logic [`CNT_W-1:0] gate_cnt, next_gate_cnt;
  logic [`CNT_W-1:0] fo_cnt, next_fo_cnt;
  logic [`CNT_W-1:0] to_cnt, next_to_cnt;
  logic [`CNT_W-1:0] half_sel;
  logic              next_clock_out, next_bus_reset, next_nvm_wr, next_irq_oe_n;
  logic              req_q, next_req_q, ack_tog, next_ack_tog;
  rtc_pkg::nvm_req_s next_nvm_wdata;
  logic              foe_s, osc_s, req_s, open_s, gate_ok, req_edge;
  logic              gate_ok_q;
  // link side state
  logic              open, next_open, byte_done, next_byte_done;
  logic              req_tog, next_req_tog;
  rtc_pkg::nvm_req_s hold, next_hold;
  logic              ok_l, ack_l, rst_l, pend;

  rtc_sync2 #(.W(4)) u_sync_m (
    .clk_i    (mclk_i),
    .resetn_i (resetn_i),
    .d_i      ({clock_out_enable_pin_i, osc_running_i, req_tog, open}),
    .q_o      ({foe_s, osc_s, req_s, open_s})
  );

  rtc_sync2 #(.W(3)) u_sync_l (
    .clk_i    (bus_clk_i),
    .resetn_i (resetn_i),
    // registered first so no glitch of the gate decode reaches the other domain
    .d_i      ({gate_ok_q, ack_tog, bus_reset_o}),
    .q_o      ({ok_l, ack_l, rst_l})
  );

  // clock output divider; reset value starts the fast rate
  always_comb begin
    unique case (fsel_i)
      `FSEL_MID: half_sel = HALF_MD_CYC;
      `FSEL_LO:  half_sel = HALF_LO_CYC;
      default:   half_sel = `CNT_W'(`HALF_HI_CYC);
    endcase
    next_fo_cnt    = fo_cnt + `CNT_W'(1);
    next_clock_out = clock_out_pin_o;
    if (fo_cnt >= half_sel - `CNT_W'(1)) begin
      next_fo_cnt    = '0;
      next_clock_out = ~clock_out_pin_o;
    end
    next_irq_oe_n = ~(|irq_src_i);
  end

  // nonvolatile gate: power-up lockout, then idle or write cycle
  assign gate_ok  = (state == rtc_pkg::ST_IDLE) && osc_s && nvm_write_permit_i;
  assign req_edge = req_s ^ req_q;

  always_comb begin
    next_state     = state;
    next_gate_cnt  = gate_cnt + `CNT_W'(1);
    next_nvm_wr    = 1'b0;
    next_nvm_wdata = nvm_wdata_o;
    next_req_q     = req_s;
    next_ack_tog   = ack_tog;
    unique case (state)
      rtc_pkg::ST_LOCKOUT: begin
        if (gate_cnt >= PUA_CYC - `CNT_W'(1)) begin
          next_state    = rtc_pkg::ST_IDLE;
          next_gate_cnt = '0;
        end
      end
      rtc_pkg::ST_IDLE: begin
        next_gate_cnt = '0;
      end
      rtc_pkg::ST_BUSY: begin
        if (gate_cnt >= WR_CYC - `CNT_W'(1)) begin
          next_state    = rtc_pkg::ST_IDLE;
          next_gate_cnt = '0;
        end
      end
    endcase
    if (req_edge) begin
      // recheck here: the link side saw gate_ok two of its cycles late
      next_ack_tog = req_s;
      if (gate_ok) begin
        next_state     = rtc_pkg::ST_BUSY;
        next_gate_cnt  = '0;
        next_nvm_wr    = 1'b1;
        next_nvm_wdata = hold;
      end
    end
  end

  // transaction watchdog; cleared only once the link side has dropped open
  always_comb begin
    next_to_cnt    = '0;
    next_bus_reset = bus_reset_o;
    if (!open_s) begin
      next_bus_reset = 1'b0;
    end else if (!bus_reset_o) begin
      next_to_cnt = to_cnt + `CNT_W'(1);
      if (to_cnt >= BUSTO_CYC - `CNT_W'(1)) begin
        next_bus_reset = 1'b1;
        next_to_cnt    = '0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                <= rtc_pkg::ST_LOCKOUT;
      gate_cnt             <= '0;
      fo_cnt               <= '0;
      to_cnt               <= '0;
      clock_out_pin_o      <= 1'b0;
      clock_out_pin_oe_n_o <= 1'b1;
      irq_oe_n_o           <= 1'b1;
      bus_reset_o          <= 1'b0;
      nvm_wr_o             <= 1'b0;
      nvm_wdata_o          <= '0;
      req_q                <= 1'b0;
      ack_tog              <= 1'b0;
      gate_ok_q            <= 1'b0;
    end else begin
      state                <= next_state;
      gate_cnt             <= next_gate_cnt;
      fo_cnt               <= next_fo_cnt;
      to_cnt               <= next_to_cnt;
      clock_out_pin_o      <= next_clock_out;
      clock_out_pin_oe_n_o <= ~foe_s;
      irq_oe_n_o           <= next_irq_oe_n;
      bus_reset_o          <= next_bus_reset;
      nvm_wr_o             <= next_nvm_wr;
      nvm_wdata_o          <= next_nvm_wdata;
      req_q                <= next_req_q;
      ack_tog              <= next_ack_tog;
      gate_ok_q            <= gate_ok;
    end
  end

  // open-drain interrupt line only ever pulls low
  assign irq_n_o = 1'b0;

  // link side: one byte per transaction, refused while a request is in flight
  assign pend        = req_tog ^ ack_l;
  assign wr_ack_o    = wr_req_i && open && !byte_done && !pend && ok_l && !rst_l;
  assign wr_nack_o   = wr_req_i && !wr_ack_o;
  assign bus_abort_o = rst_l;

  always_comb begin
    next_open      = open;
    next_byte_done = byte_done;
    next_req_tog   = req_tog;
    next_hold      = hold;
    if (bus_start_i) begin
      next_open      = 1'b1;
      next_byte_done = 1'b0;
    end
    // a byte taken with a start in the same cycle still counts: set wins
    if (wr_ack_o) begin
      next_byte_done = 1'b1;
      next_req_tog   = ~req_tog;
      next_hold      = wr_data_i;
    end
    if (bus_stop_i || rst_l) begin
      next_open = 1'b0;
    end
  end

  always_ff @(posedge bus_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      open      <= 1'b0;
      byte_done <= 1'b0;
      req_tog   <= 1'b0;
      hold      <= '0;
    end else begin
      open      <= next_open;
      byte_done <= next_byte_done;
      req_tog   <= next_req_tog;
      hold      <= next_hold;
    end
  end

  sequence s_wr_strobe;
    nvm_wr_o;
  endsequence
  sequence s_wr_quiet;
    !nvm_wr_o [*8];
  endsequence

  chk_clock_out_pin_hiz: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !foe_s |=> clock_out_pin_oe_n_o) else $error("clock output driven while disabled");
  chk_clock_out_pin_fast: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (fsel_i == `FSEL_HI_B && fo_cnt == `CNT_W'(`HALF_HI_CYC) - `CNT_W'(1))
    |=> (clock_out_pin_o != $past(clock_out_pin_o))) else $error("fast clock half period wrong");
  chk_clock_out_pin_start: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (fsel_i == `FSEL_HI_A && fo_cnt < `CNT_W'(`HALF_HI_CYC) - `CNT_W'(1))
    |=> $stable(clock_out_pin_o)) else $error("clock output toggled early");
  chk_irq_low: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (|irq_src_i) |=> !irq_oe_n_o && !irq_n_o) else $error("interrupt line not pulled low");
  chk_lock_nowr: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    state == rtc_pkg::ST_LOCKOUT |=> !nvm_wr_o) else $error("write during power-up lockout");
  chk_osc_nowr: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    nvm_wr_o |-> $past(osc_s) && $past(nvm_write_permit_i)) else $error("write without osc or permit");
  chk_busy_gap: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_wr_strobe |=> s_wr_quiet) else $error("write strobes too close");
  chk_bus_timeout: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (open_s && !bus_reset_o && to_cnt == BUSTO_CYC - `CNT_W'(1)) |=> bus_reset_o)
    else $error("watchdog did not fire");
  chk_one_byte: assert property (@(posedge bus_clk_i) disable iff (!resetn_i)
    wr_ack_o |=> !wr_ack_o) else $error("second byte taken in one transaction");
endmodule : rtc_ctl
`default_nettype wire

// *** rtc_host.sv ***
/*
  Behavioural bus host facing the link side of rtc_ctl.
  Assumes a free-running link clock that it gates to run only within frames.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_host (
  // link clock
  input  wire logic              bclk_free_i,
  output var  logic              bus_clk_o,
  // front end of the block
  input  wire logic              wr_ack_i,
  input  wire logic              wr_nack_i,
  input  wire logic              bus_abort_i,
  output var  logic              bus_start_o,
  output var  logic              bus_stop_o,
  output var  logic              wr_req_o,
  output var  rtc_pkg::nvm_req_s wr_data_o
);
  logic run = 1'b0;
  // gated on the low phase so the link clock never glitches
  assign bus_clk_o = bclk_free_i & run;
  initial begin
    bus_start_o = 1'b0;
    bus_stop_o = 1'b0;
    wr_req_o = 1'b0;
    wr_data_o = 12'hA5A;
  end
  // open_cyc stays small in normal use so a frame ends well inside the timeout
  task automatic frame(input int nwr, input rtc_pkg::nvm_req_s d, input int open_cyc,
                       output logic [3:0] resp, output logic aborted);
    resp = 4'h0;
    aborted = 1'b0;
    @(negedge bclk_free_i);
    run = 1'b1;
    repeat (3) @(posedge bus_clk_o);
    bus_start_o <= 1'b1;
    @(posedge bus_clk_o);
    bus_start_o <= 1'b0;
    for (int i = 0; i < nwr; i++) begin
      wr_req_o <= 1'b1;
      wr_data_o <= d;
      @(posedge bus_clk_o);
      resp = {resp[1:0], wr_ack_i, wr_nack_i};
      wr_req_o <= 1'b0;
      // released data shows the inverse, never the last value
      wr_data_o <= rtc_pkg::nvm_req_s'(~d);
      @(posedge bus_clk_o);
    end
    for (int i = 0; i < open_cyc; i++) begin
      @(posedge bus_clk_o);
      aborted |= bus_abort_i;
    end
    bus_stop_o <= 1'b1;
    @(posedge bus_clk_o);
    bus_stop_o <= 1'b0;
    repeat (4) @(posedge bus_clk_o);
    @(negedge bclk_free_i);
    run = 1'b0;
  endtask : frame
endmodule : rtc_host
`default_nettype wire

// *** tb.sv ***
/*
  Self-checking bench for rtc_ctl with shortened counts.
  Assumes rtc_host as the link-side partner.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module tb;
  localparam int PUA = 32'hC8;
  localparam int WR = 32'h190;
  localparam int LO = 32'h12C;
  localparam int MD = 32'h3C;
  logic mclk = 1'b0;
  logic bclk = 1'b0;
  logic resetn = 1'b0;
  logic oe_pin = 1'b1;
  logic osc = 1'b0;
  logic permit = 1'b0;
  rtc_pkg::fsel_t fsel = 2'h0;
  rtc_pkg::irq_src_s src = 3'h0;
  logic cko, cko_oe_n, irq_n, irq_oe_n, nvm_wr, bus_rst, bus_clk, start, stop, req;
  logic ack, nack, abort, ab;
  logic rst_seen = 1'b0;
  logic [3:0] r;
  rtc_pkg::nvm_req_s wdata, wdin;
  int failures = 0;
  int check_count = 0;
  int pulses = 0;
  always #4 mclk = ~mclk;
  initial begin
    #1.3;
    forever #80 bclk = ~bclk;
  end
  always @(posedge mclk) begin
    if (nvm_wr === 1'b1) pulses++;
    if (bus_rst === 1'b1) rst_seen = 1'b1;
  end
  rtc_ctl #(.PUA_CYC(27'(PUA)), .WR_CYC(27'(WR)), .BUSTO_CYC(27'h1F4),
            .HALF_LO_CYC(27'(LO)), .HALF_MD_CYC(27'(MD))) i_dut (
    .mclk_i(mclk), .bus_clk_i(bus_clk), .resetn_i(resetn),
    .clock_out_enable_pin_i(oe_pin), .osc_running_i(osc), .clock_out_pin_o(cko),
    .clock_out_pin_oe_n_o(cko_oe_n), .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n),
    .fsel_i(fsel), .nvm_write_permit_i(permit), .irq_src_i(src), .nvm_wr_o(nvm_wr),
    .nvm_wdata_o(wdata), .bus_reset_o(bus_rst), .bus_start_i(start), .bus_stop_i(stop),
    .wr_req_i(req), .wr_data_i(wdin), .wr_ack_o(ack), .wr_nack_o(nack), .bus_abort_o(abort));
  rtc_host i_host (.bclk_free_i(bclk), .bus_clk_o(bus_clk), .wr_ack_i(ack), .wr_nack_i(nack),
    .bus_abort_i(abort), .bus_start_o(start), .bus_stop_o(stop), .wr_req_o(req),
    .wr_data_o(wdin));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic timed_out;
    failures++;
    test_done;
  endtask : timed_out
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // second interval between toggles; the first may be cut by a select change
  task automatic half(output int c);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = cko;
      c = 0;
      while (cko === v) begin
        tick(1);
        c++;
        if (c > 5000) timed_out;
      end
    end
  endtask : half
  task automatic s_lockout;
    // oscillator and permit both on, so only the lockout can refuse this byte
    osc <= 1'b1;
    permit <= 1'b1;
    i_host.frame(1, 12'h5A3, 0, r, ab);
    check("lockout resp", r, 4'h1);
    check("lockout writes", pulses, 32'h0);
  endtask : s_lockout
  task automatic s_clock;
    int c;
    int exp_h[4] = '{`HALF_HI_CYC, MD, LO, `HALF_HI_CYC};
    tick(1);
    half(c);
    check("default half", c, `HALF_HI_CYC);
    check("driven", cko_oe_n, 1'b0);
    for (int k = 0; k < 4; k++) begin
      tick(1);
      fsel <= 2'(k);
      half(c);
      check("half period", c, exp_h[k]);
    end
    oe_pin <= 1'b0;
    tick(6);
    check("high z", cko_oe_n, 1'b1);
    oe_pin <= 1'b1;
    tick(6);
    check("driven again", cko_oe_n, 1'b0);
  endtask : s_clock
  task automatic s_irq;
    for (int k = 0; k < 3; k++) begin
      tick(1);
      src <= 3'(1 << k);
      tick(2);
      check("irq low", {irq_oe_n, irq_n}, 2'h0);
      src <= 3'h0;
      tick(2);
      check("irq off", irq_oe_n, 1'b1);
    end
  endtask : s_irq
  task automatic s_write;
    int p;
    tick(PUA);
    osc <= 1'b0;
    tick(4);
    i_host.frame(1, 12'h1C4, 0, r, ab);
    check("osc stopped", r, 4'h1);
    tick(1);
    osc <= 1'b1;
    permit <= 1'b0;
    tick(4);
    i_host.frame(1, 12'h1C4, 0, r, ab);
    check("permit off", r, 4'h1);
    tick(1);
    permit <= 1'b1;
    tick(4);
    p = pulses;
    i_host.frame(1, 12'h9E7, 0, r, ab);
    check("permit on", r, 4'h2);
    tick(4);
    check("one write", pulses, p + 1);
    check("write data", wdata, 12'h9E7);
    i_host.frame(1, 12'h3B0, 0, r, ab);
    check("write busy", r, 4'h1);
    // spacing a well-behaved host keeps between byte writes
    tick(WR);
    i_host.frame(2, 12'h6D1, 0, r, ab);
    check("second byte", r, 4'h9);
    tick(4);
    check("single store", pulses, p + 2);
    check("stored byte", wdata, 12'h6D1);
  endtask : s_write
  task automatic s_watchdog;
    check("no early trip", rst_seen, 1'b0);
    i_host.frame(0, 12'h000, 40, r, ab);
    check("abort", {rst_seen, ab}, 2'h3);
    tick(WR);
    i_host.frame(1, 12'hA52, 0, r, ab);
    check("after abort", r, 4'h2);
  endtask : s_watchdog
  initial begin
    tick(3);
    check("reset state", {cko_oe_n, irq_oe_n, nvm_wr, bus_rst}, 4'hC);
    resetn <= 1'b1;
    s_lockout;
    s_clock;
    s_irq;
    s_write;
    s_watchdog;
    test_done;
  end
  initial begin
    #700000;
    timed_out;
  end
endmodule : tb
`default_nettype wire
